// >>> tb/lsp_host_model.sv
// host side of the link: one byte request at a time
// assumes busy stays high until the block has finished the request
`default_nettype none
module lsp_host_model (
	// link inputs
	input wire logic link_clk_in,
	input wire logic busy_in,
	input wire logic [7:0] rd_data_in,
	// requests
	output logic wr_stb_out = 1'b0,
	output logic rd_stb_out = 1'b0,
	output logic first_out = 1'b0,
	output logic [7:0] wr_data_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// strobe for one link edge, then wait for busy low under a bound
	task automatic xfer(input logic rd, input logic fst, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(negedge link_clk_in);
		rd_stb_out = rd;
		wr_stb_out = !rd;
		first_out = fst;
		wr_data_out = d;
		@(negedge link_clk_in);
		rd_stb_out = 1'b0;
		wr_stb_out = 1'b0;
		wr_data_out = ~d; // released line must not look valid
		n = 0;
		while (busy_in !== 1'b0 && n < 60) begin
			@(negedge link_clk_in);
			n++;
		end
		q = rd_data_in;
	endtask : xfer
endmodule : lsp_host_model
`default_nettype wire

// >>> tb/lsp_regs_assertions.sv
// checker of the light sensor pointer block
// assumes the bind below places it inside lsp_regs
`default_nettype none
module lsp_regs_chk (
	// clocks and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic link_clk_in,
	// link side
	input wire logic link_wr_stb_in,
	input wire logic link_rd_stb_in,
	input wire logic link_busy_out,
	input wire logic link_rd_valid_out,
	input wire logic [7:0] link_rd_data_out,
	// engine side
	input wire lsp_pkg::lsp_cfg_t cfg_out,
	input wire logic light_irq_clr_out
);
	// a request taken by the link logic
	sequence s_take;
		(link_wr_stb_in || link_rd_stb_in) && !link_busy_out;
	endsequence
	chk_busy_take: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
		s_take |=> link_busy_out) else $error("busy not raised on request");
	chk_busy_ends: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
		$rose(link_busy_out) |-> ##[1:40] !link_busy_out) else $error("busy stuck");
	chk_valid_pulse: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
		link_rd_valid_out |=> !link_rd_valid_out) else $error("valid too long");
	chk_valid_idle: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
		link_rd_valid_out |-> !link_busy_out) else $error("valid while busy");
	chk_data_hold: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
		$changed(link_rd_data_out) |-> link_rd_valid_out) else $error("read data moved");
	chk_clr_pulse: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		light_irq_clr_out |=> !light_irq_clr_out) else $error("clear not released");
	chk_rst_timer: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		$fell(sys_rst_in) |-> cfg_out.integration_length == 8'hff
		&& cfg_out.wait_length == 8'hff) else $error("timer reset value");
	chk_rst_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		$fell(sys_rst_in) |-> cfg_out.function_enable == 8'h00 && cfg_out.low_limit == 16'h0000
		&& cfg_out.gain_control == 8'h00) else $error("zero reset value");
	// config may only move while a request is in flight
	chk_cfg_quiet: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!link_busy_out [*8] |=> $stable(cfg_out)) else $error("config moved while idle");
endmodule : lsp_regs_chk

bind lsp_regs lsp_regs_chk chk_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
	.link_clk_in(link_clk_in), .link_wr_stb_in(link_wr_stb_in),
	.link_rd_stb_in(link_rd_stb_in), .link_busy_out(link_busy_out),
	.link_rd_valid_out(link_rd_valid_out), .link_rd_data_out(link_rd_data_out),
	.cfg_out(cfg_out), .light_irq_clr_out(light_irq_clr_out));
`default_nettype wire

// >>> tb/tb_lsp_regs.sv
// self-checking bench of the light sensor pointer block
// assumes lsp_regs, its checker and the host model are compiled first
`default_nettype none
`include "lsp_map.svh"
module tb_lsp_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic link_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ws, rs, fs, busy, rv, clr, inc = 1'b0;
	logic [7:0] wd, rdat, q, mem [32];
	logic [15:0] ch0 = 16'h1234;
	logic [15:0] ch1 = 16'hab56;
	logic [7:0] st = 8'h2d;
	logic [4:0] ptr = 5'h00;
	lsp_pkg::lsp_cfg_t cfg;
	int fails = 0;
	int num_checks = 0;
	int pulses = 0;
	int valids = 0;
	// core clock, link clock offset in phase
	always #5 core_clk_in = ~core_clk_in;
	initial #3.1 forever #7.5 link_clk_in = ~link_clk_in;
	lsp_regs dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.link_clk_in(link_clk_in), .link_wr_stb_in(ws), .link_rd_stb_in(rs),
		.link_first_in(fs), .link_wr_data_in(wd), .link_busy_out(busy),
		.link_rd_valid_out(rv), .link_rd_data_out(rdat), .ch0_count_in(ch0),
		.ch1_count_in(ch1), .device_state_in(st), .cfg_out(cfg), .light_irq_clr_out(clr));
	lsp_host_model host_u (.link_clk_in(link_clk_in), .busy_in(busy), .rd_data_in(rdat),
		.wr_stb_out(ws), .rd_stb_out(rs), .first_out(fs), .wr_data_out(wd));
	// count clear pulses
	always @(posedge core_clk_in) begin
		if (clr === 1'b1) pulses++;
	end
	// count read-valid pulses mid-cycle, one per answered read
	always @(negedge link_clk_in) begin
		if (rv === 1'b1) valids++;
	end
	// a request whose busy never drops is a hang; count it and close the run
	task automatic done_chk;
		if (busy !== 1'b0) begin
			fails++;
			$display("MISMATCH t=%0t busy stuck", $time);
			report_and_stop();
		end
	endtask : done_chk
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// write a byte and track pointer, mode and register image
	task automatic wr(input logic [7:0] b, input logic fst);
		host_u.xfer(1'b0, fst, b, q);
		done_chk();
		if (fst && b[7]) begin
			if (!b[6]) begin
				ptr = b[4:0];
				inc = b[5];
			end
		end else begin
			if (ptr inside {0, 1, 3, 4, 5, 6, 7, 12, 13, 15}) mem[ptr] = b;
			ptr = ptr + 5'(inc);
		end
	endtask : wr
	task automatic rd;
		host_u.xfer(1'b1, 1'b0, 8'h00, q);
		done_chk();
		chk(q, mem[ptr]);
		ptr = ptr + 5'(inc);
	endtask : rd
	task automatic report_and_stop;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// hang guard, far beyond the expected run
	initial begin
		#100us;
		fails++;
		$display("MISMATCH t=%0t watchdog", $time);
		report_and_stop();
	end
	// main sequence
	initial begin
		for (int a = 0; a < 32; a++) mem[a] = 8'h00;
		mem[1] = 8'hff;
		mem[3] = 8'hff;
		mem[18] = `LSP_DEVICE_CODE_DEF;
		mem[19] = st;
		{mem[21], mem[20]} = ch0;
		{mem[23], mem[22]} = ch1;
		repeat (6) @(negedge core_clk_in);
		sys_rst_in = 1'b0;
		repeat (8) @(negedge core_clk_in);
		rd();
		rd();
		wr(8'ha0, 1'b1);
		for (int i = 0; i < 32; i++) rd();
		wr(8'ha4, 1'b1);
		for (int i = 0; i < 4; i++) wr(8'h11 + 8'(i), 1'b0);
		chk(cfg.low_limit[15:8], 8'h12);
		chk(cfg.high_limit[7:0], 8'h13);
		wr(8'h8c, 1'b1);
		wr(8'h33, 1'b0);
		wr(8'h44, 1'b0);
		rd();
		rd();
		chk(cfg.filter_count, 8'h44);
		wr(8'h94, 1'b1);
		wr(8'h77, 1'b0);
		wr(8'h82, 1'b1);
		wr(8'h66, 1'b0);
		rd();
		wr(8'h8d, 1'b1);
		wr(8'hc1, 1'b1);
		wr(8'h5c, 1'b1);
		chk(cfg.setup_options, 8'h5c);
		wr(8'he6, 1'b1);
		wr(8'he0, 1'b1);
		rd();
		chk(8'(pulses), 8'h01);
		ch0 = 16'h9a3c;
		{mem[21], mem[20]} = ch0;
		wr(8'ha0, 1'b1);
		for (int i = 0; i < 32; i++) rd();
		repeat (2) @(negedge link_clk_in);
		chk(8'(valids), 8'h46);
		report_and_stop();
	end
endmodule : tb_lsp_regs
`default_nettype wire

// >>> verilog/lsp_map.svh
// register offsets, command fields, reset values and codes of the light sensor pointer block
// assumes it is included by the package and by the register module
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH

// register offsets (5-bit pointer space)
`define LSP_OFS_FUNCTION_ENABLE 5'h00
`define LSP_OFS_INTEGRATION_LENGTH 5'h01
`define LSP_OFS_WAIT_LENGTH 5'h03
`define LSP_OFS_LOW_LIMIT_LSB 5'h04
`define LSP_OFS_LOW_LIMIT_MSB 5'h05
`define LSP_OFS_HIGH_LIMIT_LSB 5'h06
`define LSP_OFS_HIGH_LIMIT_MSB 5'h07
`define LSP_OFS_FILTER_COUNT 5'h0c
`define LSP_OFS_SETUP_OPTIONS 5'h0d
`define LSP_OFS_GAIN_CONTROL 5'h0f
`define LSP_OFS_DEVICE_CODE 5'h12
`define LSP_OFS_DEVICE_STATE 5'h13
`define LSP_OFS_CH0_COUNT_LSB 5'h14
`define LSP_OFS_CH0_COUNT_MSB 5'h15
`define LSP_OFS_CH1_COUNT_LSB 5'h16
`define LSP_OFS_CH1_COUNT_MSB 5'h17

// reset values
`define LSP_RST_ZERO 8'h00
`define LSP_RST_TIMER 8'hff
`define LSP_RST_CMD 8'h00

// command byte layout
`define LSP_CMD_SEL_BIT 7
`define LSP_CMD_KIND_HI 6
`define LSP_CMD_KIND_LO 5
`define LSP_CMD_ADDR_HI 4

// special-function codes
`define LSP_SF_NOP 5'h00
`define LSP_SF_LIGHT_IRQ_CLR 5'h06

// identity value, arbitrary
`define LSP_DEVICE_CODE_DEF 8'h5a

`endif

// >>> verilog/lsp_pkg.sv
// types of the light sensor pointer block
// assumes lsp_map.svh is on the include path
`default_nettype none
`include "lsp_map.svh"

package lsp_pkg;

	// transaction kind in command bits 6:5
	typedef enum logic [1:0] {
		LSP_KIND_REPEAT = 2'h0,
		LSP_KIND_AUTOINC = 2'h1,
		LSP_KIND_RSVD = 2'h2,
		LSP_KIND_SPECIAL = 2'h3
	} lsp_kind_t;

	// one byte-level request from the link side
	typedef struct packed {
		logic is_read;
		logic first;
		logic [7:0] data;
	} lsp_xfer_t;

	// writable register contents handed to the sensor engines
	typedef struct packed {
		logic [7:0] function_enable;
		logic [7:0] integration_length;
		logic [7:0] wait_length;
		logic [15:0] low_limit;
		logic [15:0] high_limit;
		logic [7:0] filter_count;
		logic [7:0] setup_options;
		logic [7:0] gain_control;
	} lsp_cfg_t;

endpackage : lsp_pkg

`default_nettype wire

// >>> verilog/lsp_regs.sv
// register map and command-pointer decoder of the light sensor
// assumes a serial framer on link_clk_in delivering bytes, and engines on core_clk_in
`default_nettype none
`include "lsp_map.svh"

module lsp_regs (
	// core clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// link side, all on link_clk_in
	input wire logic link_clk_in,
	input wire logic link_wr_stb_in,
	input wire logic link_rd_stb_in,
	input wire logic link_first_in,
	input wire logic [7:0] link_wr_data_in,
	output logic link_busy_out,
	output logic link_rd_valid_out,
	output logic [7:0] link_rd_data_out,
	// engine side, on core_clk_in
	input wire logic [15:0] ch0_count_in,
	input wire logic [15:0] ch1_count_in,
	input wire logic [7:0] device_state_in,
	output lsp_pkg::lsp_cfg_t cfg_out,
	output logic light_irq_clr_out
);

	// link domain
	// the framer talks to this side one byte at a time, on link_clk_in only
	// a taken strobe flips req_tog_q and raises busy in the same edge
	// xfer_q is frozen from that edge until the ack comes back
	// so the core may read it as bundled data without its own flops
	// only the toggle itself passes through a two-flop synchroniser
	// the core answers by flipping ack_tog_q when the byte is handled
	// the returning flip passes two link flops and then frees busy
	// a read byte is loaded into core_rd_byte_q in the same edge the ack flips
	// so by the time the link copies it, that byte has long settled
	// cost per byte: about three link edges plus three core edges
	// trade-off: no buffering, so the framer must stretch the serial clock
	// or hold off its next byte while busy is high
	// strobes that arrive while busy is high are dropped, not queued
	// the scheme does not care about the ratio of the two clocks
	// link reset is sys_rst_in through two link flops, so it lags a little

	logic lrst_meta_q;
	logic lrst_q;
	logic req_tog_q;
	logic busy_q;
	lsp_pkg::lsp_xfer_t xfer_q;
	logic ack_meta_q;
	logic ack_sync_q;
	logic ack_prev_q;
	logic rd_valid_q;
	logic [7:0] rd_data_q;
	// answer side of the core, declared here because the link logic reads it
	logic ack_tog_q;
	logic [7:0] core_rd_byte_q;
	logic ack_edge;

	// reset brought into the link clock; needs a few link edges after release
	always_ff @(posedge link_clk_in) begin
		lrst_meta_q <= sys_rst_in;
		lrst_q <= lrst_meta_q;
	end

	// returning acknowledge toggle, two stages before use
	always_ff @(posedge link_clk_in) begin
		if (lrst_q) begin
			ack_meta_q <= 1'b0;
			ack_sync_q <= 1'b0;
			ack_prev_q <= 1'b0;
		end else begin
			ack_meta_q <= ack_tog_q;
			ack_sync_q <= ack_meta_q;
			ack_prev_q <= ack_sync_q;
		end
	end

	assign ack_edge = ack_sync_q ^ ack_prev_q;

	// one request in flight; strobes while busy are dropped, framer must watch busy
	always_ff @(posedge link_clk_in) begin
		if (lrst_q) begin
			req_tog_q <= 1'b0;
			busy_q <= 1'b0;
			xfer_q <= '0;
		end else if (!busy_q && (link_wr_stb_in || link_rd_stb_in)) begin
			req_tog_q <= ~req_tog_q;
			busy_q <= 1'b1;
			xfer_q.is_read <= link_rd_stb_in;
			xfer_q.first <= link_first_in;
			xfer_q.data <= link_wr_data_in;
		end else if (ack_edge) begin
			busy_q <= 1'b0;
		end
	end

	// read byte is stable in the core once its ack toggles, so sampling it here is safe
	always_ff @(posedge link_clk_in) begin
		if (lrst_q) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			rd_valid_q <= ack_edge && xfer_q.is_read;
			if (ack_edge && xfer_q.is_read) begin
				rd_data_q <= core_rd_byte_q;
			end
		end
	end

	assign link_busy_out = busy_q;
	assign link_rd_valid_out = rd_valid_q;
	assign link_rd_data_out = rd_data_q;

	// core domain
	// everything below runs on core_clk_in and resets with sys_rst_in
	// a first written byte with bit 7 set is a command, never data
	// kinds 00 and 01 load the held command and the pointer
	// kind 11 only fires a special code; pointer and mode stay as they were
	// kind 10 is ignored outright, so a stray one cannot move the pointer
	// every other written byte is data for the register under the pointer
	// every read returns the byte under the pointer at the time of the request
	// in auto-increment the pointer steps after each data byte, read or write
	// it wraps from the top of the 5-bit space back to zero
	// 16-bit values are plain byte pairs, low byte at the lower address
	// counts are sampled per byte; a host reading both halves across a
	// conversion may see halves from two different results
	// holes and read-only spots swallow writes and holes read zero

	logic req_meta_q;
	logic req_sync_q;
	logic req_prev_q;
	logic [7:0] cmd_q;
	logic [4:0] ptr_q;
	logic irq_clr_q;
	lsp_pkg::lsp_cfg_t cfg_q;
	logic req_edge;
	logic cmd_hit;
	logic data_wr;
	logic data_rd;
	lsp_pkg::lsp_kind_t kind;
	lsp_pkg::lsp_kind_t held_kind;

	// xfer_q is held steady from toggle to ack, so it is read directly after the edge
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			req_meta_q <= 1'b0;
			req_sync_q <= 1'b0;
			req_prev_q <= 1'b0;
		end else begin
			req_meta_q <= req_tog_q;
			req_sync_q <= req_meta_q;
			req_prev_q <= req_sync_q;
		end
	end

	assign req_edge = req_sync_q ^ req_prev_q;

	// a first written byte with msb set is a command, anything else written is data
	assign cmd_hit = req_edge && !xfer_q.is_read && xfer_q.first
		&& xfer_q.data[`LSP_CMD_SEL_BIT];
	assign data_wr = req_edge && !xfer_q.is_read && !cmd_hit;
	assign data_rd = req_edge && xfer_q.is_read;
	assign kind = lsp_pkg::lsp_kind_t'(xfer_q.data[`LSP_CMD_KIND_HI:`LSP_CMD_KIND_LO]);
	assign held_kind = lsp_pkg::lsp_kind_t'(cmd_q[`LSP_CMD_KIND_HI:`LSP_CMD_KIND_LO]);

	// read decode; holes read zero
	// the counts and the status byte are taken live from the engine side
	// the identity byte is a constant of this block
	function automatic logic [7:0] read_mux(input logic [4:0] a, input lsp_pkg::lsp_cfg_t c,
		input logic [15:0] c0, input logic [15:0] c1, input logic [7:0] st);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`LSP_OFS_FUNCTION_ENABLE: v = c.function_enable;
			`LSP_OFS_INTEGRATION_LENGTH: v = c.integration_length;
			`LSP_OFS_WAIT_LENGTH: v = c.wait_length;
			`LSP_OFS_LOW_LIMIT_LSB: v = c.low_limit[7:0];
			`LSP_OFS_LOW_LIMIT_MSB: v = c.low_limit[15:8];
			`LSP_OFS_HIGH_LIMIT_LSB: v = c.high_limit[7:0];
			`LSP_OFS_HIGH_LIMIT_MSB: v = c.high_limit[15:8];
			`LSP_OFS_FILTER_COUNT: v = c.filter_count;
			`LSP_OFS_SETUP_OPTIONS: v = c.setup_options;
			`LSP_OFS_GAIN_CONTROL: v = c.gain_control;
			`LSP_OFS_DEVICE_CODE: v = `LSP_DEVICE_CODE_DEF;
			`LSP_OFS_DEVICE_STATE: v = st;
			`LSP_OFS_CH0_COUNT_LSB: v = c0[7:0];
			`LSP_OFS_CH0_COUNT_MSB: v = c0[15:8];
			`LSP_OFS_CH1_COUNT_LSB: v = c1[7:0];
			`LSP_OFS_CH1_COUNT_MSB: v = c1[15:8];
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_mux

	// command register; special and reserved kinds leave the held pointer setup alone
	// the held command also holds the access mode for later data bytes
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cmd_q <= `LSP_RST_CMD;
		end else if (cmd_hit && (kind == lsp_pkg::LSP_KIND_REPEAT
			|| kind == lsp_pkg::LSP_KIND_AUTOINC)) begin
			cmd_q <= xfer_q.data;
		end
	end

	// pointer: loaded by a command, stepped after each data byte in auto-increment
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ptr_q <= 5'h00;
		end else if (cmd_hit && (kind == lsp_pkg::LSP_KIND_REPEAT
			|| kind == lsp_pkg::LSP_KIND_AUTOINC)) begin
			ptr_q <= xfer_q.data[`LSP_CMD_ADDR_HI:0];
		end else if ((data_wr || data_rd) && held_kind == lsp_pkg::LSP_KIND_AUTOINC) begin
			ptr_q <= ptr_q + 5'h01;
		end else begin
			ptr_q <= ptr_q;
		end
	end

	// interrupt clear lasts one core cycle, then releases itself
	// the engine clears its pending light interrupt on this one-cycle pulse
	// a second clear command simply gives a second pulse
	// nop and undefined special codes produce no pulse at all
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			irq_clr_q <= 1'b0;
		end else begin
			irq_clr_q <= cmd_hit && kind == lsp_pkg::LSP_KIND_SPECIAL
				&& xfer_q.data[`LSP_CMD_ADDR_HI:0] == `LSP_SF_LIGHT_IRQ_CLR;
		end
	end

	// write side of the register image
	// only the ten read/write registers take data
	// the identity and status spots are read-only and never change here
	// the channel counts belong to the engines and are only read
	// a write to a hole leaves the whole image as it was
	// no byte enables are needed, every write is one whole byte
	// data writes land at the pointer; read-only and holes fall through untouched
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cfg_q.function_enable <= `LSP_RST_ZERO;
			cfg_q.integration_length <= `LSP_RST_TIMER;
			cfg_q.wait_length <= `LSP_RST_TIMER;
			cfg_q.low_limit <= {`LSP_RST_ZERO, `LSP_RST_ZERO};
			cfg_q.high_limit <= {`LSP_RST_ZERO, `LSP_RST_ZERO};
			cfg_q.filter_count <= `LSP_RST_ZERO;
			cfg_q.setup_options <= `LSP_RST_ZERO;
			cfg_q.gain_control <= `LSP_RST_ZERO;
		end else if (data_wr) begin
			unique case (ptr_q)
				`LSP_OFS_FUNCTION_ENABLE: cfg_q.function_enable <= xfer_q.data;
				`LSP_OFS_INTEGRATION_LENGTH: cfg_q.integration_length <= xfer_q.data;
				`LSP_OFS_WAIT_LENGTH: cfg_q.wait_length <= xfer_q.data;
				`LSP_OFS_LOW_LIMIT_LSB: cfg_q.low_limit[7:0] <= xfer_q.data;
				`LSP_OFS_LOW_LIMIT_MSB: cfg_q.low_limit[15:8] <= xfer_q.data;
				`LSP_OFS_HIGH_LIMIT_LSB: cfg_q.high_limit[7:0] <= xfer_q.data;
				`LSP_OFS_HIGH_LIMIT_MSB: cfg_q.high_limit[15:8] <= xfer_q.data;
				`LSP_OFS_FILTER_COUNT: cfg_q.filter_count <= xfer_q.data;
				`LSP_OFS_SETUP_OPTIONS: cfg_q.setup_options <= xfer_q.data;
				`LSP_OFS_GAIN_CONTROL: cfg_q.gain_control <= xfer_q.data;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// read byte captured from the pointer before it steps, in the edge the ack goes back
	// ack flips once per request, read or write, so busy always ends
	// the read byte is loaded in the same edge the ack flips
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			core_rd_byte_q <= 8'h00;
			ack_tog_q <= 1'b0;
		end else if (req_edge) begin
			ack_tog_q <= ~ack_tog_q;
			if (data_rd) begin
				core_rd_byte_q <= read_mux(ptr_q, cfg_q, ch0_count_in, ch1_count_in,
					device_state_in);
			end
		end
	end

	assign cfg_out = cfg_q;
	assign light_irq_clr_out = irq_clr_q;

endmodule : lsp_regs

`default_nettype wire
